// File: design/info_framer_regs.vh
// Function
// R1: identification packet type 0x4944, length 5+N
// R2: id payload: serial, model text, zero
// R3: model text: version, space, part number
// R4: version packet type 0x5652, length 5
// R5: version bytes major, minor, patch, stage, build
// R6: stage codes 0 rc,1 dev,2 alpha,3 beta
// R7: released firmware reports zero stage, build
// R8: test packet type 0x5430, length 0x1C
// R9: test payload fourteen 16-bit fields, in order
// R10: sensor packet type 0x5330, length 0x1E
// R11: sensor packet polled or streamed continuously
// R12: thirteen sensor words, MSB first, fixed order
// R13: rate scale 1260 deg per 65536
// R14: accel scale 20 g per 65536
// R15: magnet scale conflict settled as 20/65536
// R16: temperature scale 200 C per 65536
// R17: gps word not implemented; status at 28
// R18: host requests id, version, test packets
// R19: failed request answered by error packet 0x1515
// R20: frame: 0x5555, type, length, payload, crc
// R21: two's complement fields, MSB first everywhere
`ifndef INFO_FRAMER_REGS_VH
`define INFO_FRAMER_REGS_VH

`define ADDR_CTRL 8'h00
`define ADDR_REQ 8'h01
`define ADDR_STATUS 8'h02
`define ADDR_SERIAL_HI 8'h03
`define ADDR_SERIAL_LO 8'h04
`define ADDR_VER_MAJ_MIN 8'h05
`define ADDR_VER_PATCH_STAGE 8'h06
`define ADDR_VER_BUILD 8'h07
`define ADDR_MODEL_LEN 8'h08
`define ADDR_FAILED_TYPE 8'h09
`define ADDR_MODEL_BASE 8'h40
`define MODEL_DEPTH 32
`define MODEL_AW 5

`define CTRL_STREAM_BIT 0
`define CTRL_RELEASED_BIT 1
`define STATUS_BUSY_BIT 0
`define STATUS_POLL_PEND_BIT 1
`define STATUS_STREAM_PEND_BIT 2
`define STATUS_ERR_BIT 3

`define PREAMBLE_BYTE 8'h55
`define TYPE_ID 16'h4944
`define TYPE_VR 16'h5652
`define TYPE_T0 16'h5430
`define TYPE_S0 16'h5330
`define TYPE_ERR 16'h1515
`define LEN_ID_BASE 8'h05
`define LEN_VR 8'h05
`define LEN_T0 8'h1C
`define LEN_S0 8'h1E
`define LEN_ERR 8'h02

`define SENSOR_WORDS 13
`define TEST_WORDS 14
`define S0_GPS_OFFSET 8'h1A
`define S0_STATUS_OFFSET 8'h1C

`endif

// File: design/word_snapshot.v
`default_nettype none
module word_snapshot #(
	parameter N = 27
) (
	input wire sys_clk_i,
	input wire rst_i,
	input wire load_i,
	input wire [N*16-1:0] words_i,
	output wire [N*16-1:0] words_o
);
	// frozen copy so a frame never mixes two samples
	genvar g;
	generate
		for (g = 0; g < N; g = g + 1) begin : gen_word
			reg [15:0] held;
			always @(posedge sys_clk_i) begin
				if (rst_i) begin
					held <= 16'h0000;
				end else if (load_i) begin
					held <= words_i[g*16 +: 16];
				end
			end
			assign words_o[g*16 +: 16] = held;
		end
	endgenerate
endmodule // word_snapshot
`default_nettype wire

// File: design/info_packet_framer.v
// The address map and the strobed register port are this design's own decisions.
`include "info_framer_regs.vh"
`default_nettype none
module info_packet_framer (
	input wire sys_clk_i,
	input wire rst_i,
	input wire [7:0] addr_i,
	input wire [15:0] wdata_i,
	input wire wr_i,
	input wire rd_i,
	output reg [15:0] rdata_o,
	input wire [207:0] sensor_words_i,
	input wire [223:0] test_words_i,
	input wire stream_tick_i,
	output reg [7:0] tx_data_o,
	output reg tx_valid_o,
	input wire tx_ready_i,
	output wire crc_clear_o,
	output wire crc_take_o,
	input wire [15:0] crc_i,
	output wire busy_o
);
	localparam ST_IDLE = 4'd0;
	localparam ST_PRE1 = 4'd1;
	localparam ST_PRE2 = 4'd2;
	localparam ST_TYPEH = 4'd3;
	localparam ST_TYPEL = 4'd4;
	localparam ST_LEN = 4'd5;
	localparam ST_PAY = 4'd6;
	localparam ST_CRCW = 4'd7;
	localparam ST_CRCH = 4'd8;
	localparam ST_CRCL = 4'd9;

	reg stream_en;
	reg released;
	reg [31:0] unit_serial_value;
	reg [7:0] fw_major;
	reg [7:0] fw_minor;
	reg [7:0] fw_patch;
	reg [7:0] fw_stage;
	reg [7:0] fw_build_count;
	reg [5:0] model_len;
	reg [7:0] model_text [0:`MODEL_DEPTH-1];
	reg poll_pend;
	reg [15:0] poll_type;
	reg stream_pend;
	reg err_flag;
	reg [15:0] failed_type;

	reg [3:0] state;
	reg [7:0] idx;
	reg [15:0] cur_type;
	reg [7:0] cur_len;
	reg [3:0] next_state;
	reg [7:0] next_idx;
	reg [7:0] next_byte;

	wire [431:0] snap_words;
	wire snap_load;
	wire fire;
	wire start_poll;
	wire start_stream;
	wire req_wr;
	wire req_known;
	wire [5:0] model_n;
	wire [7:0] id_len;
	wire [7:0] stage_out;
	wire [7:0] build_out;
	wire [15:0] sel_word;
	wire [7:0] word_pos;
	reg [7:0] pay_byte;
	reg [7:0] crc_i_low;

	integer i;

	// sensor words first, then the fourteen test fields
	word_snapshot #(
		.N(27)
	) u_snap (
		.sys_clk_i(sys_clk_i),
		.rst_i(rst_i),
		.load_i(snap_load),
		.words_i({test_words_i, sensor_words_i}),
		.words_o(snap_words)
	);

	assign fire = tx_valid_o & tx_ready_i;
	assign busy_o = (state != ST_IDLE);
	assign start_poll = (state == ST_IDLE) & poll_pend;
	assign start_stream = (state == ST_IDLE) & ~poll_pend & stream_pend;
	assign snap_load = start_poll | start_stream;
	assign crc_clear_o = snap_load;
	// crc covers type, length and payload
	assign crc_take_o = fire & (state >= ST_TYPEH) & (state <= ST_PAY);
	assign req_wr = wr_i & (addr_i == `ADDR_REQ);
	// R18 only these types may be polled
	assign req_known = (wdata_i == `TYPE_ID) | (wdata_i == `TYPE_VR) |
		(wdata_i == `TYPE_T0) | (wdata_i == `TYPE_S0);
	assign model_n = (model_len > 6'd32) ? 6'd32 : model_len;
	// R1 length is five plus text count
	assign id_len = `LEN_ID_BASE + {2'b00, model_n};
	// R7 released firmware hides stage and build
	assign stage_out = released ? 8'h00 : fw_stage;
	assign build_out = released ? 8'h00 : fw_build_count;

	// register writes and request latching
	always @(posedge sys_clk_i) begin
		if (rst_i) begin
			stream_en <= 1'b0;
			released <= 1'b0;
			unit_serial_value <= 32'h00000000;
			fw_major <= 8'h00;
			fw_minor <= 8'h00;
			fw_patch <= 8'h00;
			fw_stage <= 8'h00;
			fw_build_count <= 8'h00;
			model_len <= 6'h00;
			poll_pend <= 1'b0;
			poll_type <= 16'h0000;
			stream_pend <= 1'b0;
			err_flag <= 1'b0;
			failed_type <= 16'h0000;
		end else begin
			if (wr_i) begin
				case (addr_i)
					`ADDR_CTRL: begin
						stream_en <= wdata_i[`CTRL_STREAM_BIT];
						released <= wdata_i[`CTRL_RELEASED_BIT];
					end
					`ADDR_SERIAL_HI: unit_serial_value[31:16] <= wdata_i;
					`ADDR_SERIAL_LO: unit_serial_value[15:0] <= wdata_i;
					`ADDR_VER_MAJ_MIN: begin
						fw_major <= wdata_i[15:8];
						fw_minor <= wdata_i[7:0];
					end
					`ADDR_VER_PATCH_STAGE: begin
						fw_patch <= wdata_i[15:8];
						// R6 stage code stored as written
						fw_stage <= wdata_i[7:0];
					end
					`ADDR_VER_BUILD: fw_build_count <= wdata_i[7:0];
					`ADDR_MODEL_LEN: model_len <= wdata_i[5:0];
					default: begin
					end
				endcase
			end
			// status write of one clears the error flag
			if (wr_i && addr_i == `ADDR_STATUS && wdata_i[`STATUS_ERR_BIT]) begin
				err_flag <= 1'b0;
			end
			// a new poll is accepted only once the previous one started
			if (start_poll) begin
				poll_pend <= 1'b0;
			end
			if (req_wr && (!poll_pend || start_poll)) begin
				poll_pend <= 1'b1;
				if (req_known) begin
					poll_type <= wdata_i;
				end else begin
					// R19 unknown request becomes error reply
					poll_type <= `TYPE_ERR;
					failed_type <= wdata_i;
					err_flag <= 1'b1;
				end
			end
			// R11 stream tick arms the sensor packet
			if (start_stream) begin
				stream_pend <= 1'b0;
			end
			if (stream_tick_i && stream_en) begin
				stream_pend <= 1'b1;
			end
		end
	end

	// model text memory, one byte per word address
	always @(posedge sys_clk_i) begin
		if (rst_i) begin
			for (i = 0; i < `MODEL_DEPTH; i = i + 1) begin
				model_text[i] <= 8'h00;
			end
		end else if (wr_i && addr_i[7:`MODEL_AW] == `ADDR_MODEL_BASE >> `MODEL_AW) begin
			// R3 software loads version, space, part number
			model_text[addr_i[`MODEL_AW-1:0]] <= wdata_i[7:0];
		end
	end

	// read data stands the cycle after the strobe only
	always @(posedge sys_clk_i) begin
		if (rst_i) begin
			rdata_o <= 16'h0000;
		end else if (rd_i) begin
			case (addr_i)
				`ADDR_CTRL: rdata_o <= {14'h0000, released, stream_en};
				`ADDR_REQ: rdata_o <= poll_type;
				`ADDR_STATUS: rdata_o <= {12'h000, err_flag, stream_pend, poll_pend, busy_o};
				`ADDR_SERIAL_HI: rdata_o <= unit_serial_value[31:16];
				`ADDR_SERIAL_LO: rdata_o <= unit_serial_value[15:0];
				`ADDR_VER_MAJ_MIN: rdata_o <= {fw_major, fw_minor};
				`ADDR_VER_PATCH_STAGE: rdata_o <= {fw_patch, fw_stage};
				`ADDR_VER_BUILD: rdata_o <= {8'h00, fw_build_count};
				`ADDR_MODEL_LEN: rdata_o <= {10'h000, model_len};
				`ADDR_FAILED_TYPE: rdata_o <= failed_type;
				default: begin
					if (addr_i[7:`MODEL_AW] == `ADDR_MODEL_BASE >> `MODEL_AW) begin
						rdata_o <= {8'h00, model_text[addr_i[`MODEL_AW-1:0]]};
					end else begin
						rdata_o <= 16'h0000;
					end
				end
			endcase
		end else begin
			rdata_o <= 16'h0000;
		end
	end

	// word index for two-byte fields; even offset is the high byte
	assign word_pos = {1'b0, next_idx[7:1]};
	assign sel_word = (word_pos < 8'd27) ? snap_words[word_pos[4:0]*16 +: 16] : 16'h0000;

	// payload byte at next_idx for the current packet type
	always @* begin
		pay_byte = 8'h00;
		case (cur_type)
			`TYPE_ID: begin
				// R2 serial, text, then terminating zero
				if (next_idx < 8'd4) begin
					pay_byte = unit_serial_value[8*(3-next_idx[1:0]) +: 8];
				end else if (next_idx < 8'd4 + {2'b00, model_n}) begin
					pay_byte = model_text[next_idx[`MODEL_AW-1:0] - 5'd4];
				end else begin
					pay_byte = 8'h00;
				end
			end
			`TYPE_VR: begin
				// R5 fixed byte order
				case (next_idx)
					8'd0: pay_byte = fw_major;
					8'd1: pay_byte = fw_minor;
					8'd2: pay_byte = fw_patch;
					8'd3: pay_byte = stage_out;
					8'd4: pay_byte = build_out;
					default: pay_byte = 8'h00;
				endcase
			end
			`TYPE_T0: begin
				// R9 test fields held after the sensor words
				pay_byte = next_idx[0] ? snap_words[(word_pos[4:0] + 5'd13)*16 +: 8] :
					snap_words[(word_pos[4:0] + 5'd13)*16 + 8 +: 8];
			end
			`TYPE_S0: begin
				// R17 gps word sent as zero, master status last
				if (next_idx == `S0_GPS_OFFSET || next_idx == `S0_GPS_OFFSET + 8'd1) begin
					pay_byte = 8'h00;
				end else if (next_idx >= `S0_STATUS_OFFSET) begin
					pay_byte = next_idx[0] ? snap_words[13*16 +: 8] : snap_words[13*16 + 8 +: 8];
				end else begin
					// R12 R13 R14 R15 R16 words passed unscaled
					pay_byte = next_idx[0] ? sel_word[7:0] : sel_word[15:8];
				end
			end
			default: begin
				// R19 echo of the failed request type
				pay_byte = next_idx[0] ? failed_type[7:0] : failed_type[15:8];
			end
		endcase
	end

	// frame sequencer
	always @* begin
		next_state = state;
		next_idx = idx;
		case (state)
			ST_IDLE: begin
				if (snap_load) begin
					next_state = ST_PRE1;
				end
			end
			ST_PRE1: if (fire) next_state = ST_PRE2;
			ST_PRE2: if (fire) next_state = ST_TYPEH;
			ST_TYPEH: if (fire) next_state = ST_TYPEL;
			ST_TYPEL: if (fire) next_state = ST_LEN;
			ST_LEN: begin
				if (fire) begin
					next_state = ST_PAY;
					next_idx = 8'd0;
				end
			end
			ST_PAY: begin
				if (fire) begin
					if (idx == cur_len - 8'd1) begin
						next_state = ST_CRCW;
					end else begin
						next_idx = idx + 8'd1;
					end
				end
			end
			// one idle cycle lets the external crc take the last byte
			ST_CRCW: next_state = ST_CRCH;
			ST_CRCH: if (fire) next_state = ST_CRCL;
			ST_CRCL: if (fire) next_state = ST_IDLE;
			default: next_state = ST_IDLE;
		endcase
	end

	// byte to present in the next state
	always @* begin
		case (next_state)
			// R20 preamble, type, length, payload, crc
			ST_PRE1: next_byte = `PREAMBLE_BYTE;
			ST_PRE2: next_byte = `PREAMBLE_BYTE;
			// R21 multi-byte values high byte first
			ST_TYPEH: next_byte = cur_type[15:8];
			ST_TYPEL: next_byte = cur_type[7:0];
			ST_LEN: next_byte = cur_len;
			ST_PAY: next_byte = pay_byte;
			ST_CRCH: next_byte = crc_i[15:8];
			ST_CRCL: next_byte = crc_i_low;
			default: next_byte = 8'h00;
		endcase
	end

	// low crc byte kept from the same sample as the high byte
	always @(posedge sys_clk_i) begin
		if (rst_i) begin
			crc_i_low <= 8'h00;
		end else if (state == ST_CRCW) begin
			crc_i_low <= crc_i[7:0];
		end
	end

	always @(posedge sys_clk_i) begin
		if (rst_i) begin
			state <= ST_IDLE;
			idx <= 8'd0;
			cur_type <= 16'h0000;
			cur_len <= 8'h00;
			tx_data_o <= 8'h00;
			tx_valid_o <= 1'b0;
		end else begin
			state <= next_state;
			idx <= next_idx;
			tx_data_o <= next_byte;
			tx_valid_o <= (next_state != ST_IDLE) && (next_state != ST_CRCW);
			if (snap_load) begin
				if (start_poll) begin
					cur_type <= poll_type;
				end else begin
					// R10 streamed sensor packet
					cur_type <= `TYPE_S0;
				end
			end
			if (state == ST_PRE1) begin
				case (cur_type)
					// R1 identification length
					`TYPE_ID: cur_len <= id_len;
					// R4 version length
					`TYPE_VR: cur_len <= `LEN_VR;
					// R8 test length
					`TYPE_T0: cur_len <= `LEN_T0;
					// R10 sensor length
					`TYPE_S0: cur_len <= `LEN_S0;
					default: cur_len <= `LEN_ERR;
				endcase
			end
		end
	end
endmodule // info_packet_framer
`default_nettype wire

// File: dv/info_framer_properties.sv
`default_nettype none
module info_framer_properties (
	input wire logic sys_clk_i,
	input wire logic rst_i,
	input wire logic [7:0] tx_data_o,
	input wire logic tx_valid_o,
	input wire logic tx_ready_i,
	input wire logic crc_clear_o,
	input wire logic crc_take_o,
	input wire logic busy_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] idx;
	logic [15:0] typ;
	// byte position within the frame, so checks can find the length field despite stalls
	always_ff @(posedge sys_clk_i) begin
		if (rst_i || crc_clear_o) begin
			idx <= 8'h00;
		end else if (tx_valid_o && tx_ready_i) begin
			idx <= idx + 8'h01;
			if (idx == 8'h02) typ[15:8] <= tx_data_o;
			if (idx == 8'h03) typ[7:0] <= tx_data_o;
		end
	end
	default clocking dc @(posedge sys_clk_i);
	endclocking
	default disable iff (rst_i);
	preamble_bytes_a:
		assert property (tx_valid_o && idx < 8'h02 |-> tx_data_o == 8'h55 && !crc_take_o)
		else $error("preamble byte wrong or absorbed");
	byte_hold_a:
		assert property (tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_data_o))
		else $error("byte dropped before taken");
	crc_absorb_a:
		assert property (crc_take_o |-> tx_valid_o && tx_ready_i && idx > 8'h01)
		else $error("crc take without transfer");
	frame_open_a:
		assert property (crc_clear_o |=> $rose(busy_o) && tx_valid_o && tx_data_o == 8'h55)
		else $error("frame start not cleared");
	len_version_a:
		assert property (tx_valid_o && idx == 8'h04 && typ == 16'h5652 |-> tx_data_o == 8'h05)
		else $error("version length wrong");
	len_test_a:
		assert property (tx_valid_o && idx == 8'h04 && typ == 16'h5430 |-> tx_data_o == 8'h1C)
		else $error("test length wrong");
	len_sensor_a:
		assert property (tx_valid_o && idx == 8'h04 && typ == 16'h5330 |-> tx_data_o == 8'h1E)
		else $error("sensor length wrong");
	len_error_a:
		assert property (tx_valid_o && idx == 8'h04 && typ == 16'h1515 |-> tx_data_o == 8'h02)
		else $error("error length wrong");
endmodule // info_framer_properties
bind info_packet_framer info_framer_properties props (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
	.tx_data_o(tx_data_o), .tx_valid_o(tx_valid_o), .tx_ready_i(tx_ready_i),
	.crc_clear_o(crc_clear_o), .crc_take_o(crc_take_o), .busy_o(busy_o));
`default_nettype wire

// File: dv/host_sink.sv
`default_nettype none
module host_sink (
	input wire logic sys_clk_i,
	input wire logic rst_i,
	input wire logic slow_i,
	input wire logic [7:0] tx_data_i,
	input wire logic tx_valid_i,
	output logic tx_ready_o,
	output logic got_o,
	output logic [7:0] got_data_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [1:0] pace;
	// slow host accepts one byte in three, to exercise the hold of a waiting byte
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) pace <= 2'h0;
		else pace <= (pace == 2'h2) ? 2'h0 : pace + 2'h1;
	end
	assign tx_ready_o = !rst_i && (!slow_i || pace == 2'h0);
	assign got_o = tx_valid_i && tx_ready_o;
	assign got_data_o = tx_data_i;
endmodule // host_sink
`default_nettype wire

// File: dv/polled_info_sensor_packet_framer_bench.sv
`include "info_framer_regs.vh"
`default_nettype none
module polled_info_sensor_packet_framer_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic sys_clk_i = 1'b0, rst_i = 1'b1, wr_i = 1'b0, rd_i = 1'b0, stream_tick_i = 1'b0, slow = 1'b0, rd_d = 1'b0;
	logic [7:0] addr_i = 8'h00;
	logic [15:0] wdata_i = 16'h0000, crc_i = 16'h0000;
	logic [207:0] sensor_words_i = '0;
	logic [223:0] test_words_i = '0;
	logic [15:0] rdata_o;
	logic [7:0] tx_data_o, got_data;
	logic tx_valid_o, tx_ready_i, crc_clear_o, crc_take_o, busy_o, got;
	logic [31:0] seed = 32'd96690;
	int n_fail = 0, checks = 0, cyc = 0;
	logic [7:0] eq[$], pl[$];
	logic [15:0] rq[$];
	string m = "V1 PN7";

	always #5 sys_clk_i = ~sys_clk_i;

	info_packet_framer uut (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
		.wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .sensor_words_i(sensor_words_i),
		.test_words_i(test_words_i), .stream_tick_i(stream_tick_i), .tx_data_o(tx_data_o),
		.tx_valid_o(tx_valid_o), .tx_ready_i(tx_ready_i), .crc_clear_o(crc_clear_o),
		.crc_take_o(crc_take_o), .crc_i(crc_i), .busy_o(busy_o));
	host_sink host (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .slow_i(slow), .tx_data_i(tx_data_o),
		.tx_valid_i(tx_valid_o), .tx_ready_o(tx_ready_i), .got_o(got), .got_data_o(got_data));

	function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] b);
		return {c[14:0], c[15]} ^ {8'h00, b};
	endfunction
	function automatic logic [15:0] rnd();
		for (int i = 0; i < 16; i++) seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
		return seed[15:0];
	endfunction
	task automatic cmp8(input logic [7:0] g, input logic [7:0] e);
		checks++;
		if (g !== e) begin
			n_fail++;
			$display("FAIL %0t byte %h exp %h", $time, g, e);
		end
	endtask
	task automatic cmp16(input logic [15:0] g, input logic [15:0] e);
		checks++;
		if (g !== e) begin
			n_fail++;
			$display("FAIL %0t rdata %h exp %h", $time, g, e);
		end
	endtask
	task automatic end_of_test();
		$display("checks %0d n_fail %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'b1;
		rd_i <= 1'b0;
		@(posedge sys_clk_i);
	endtask
	task automatic rd(input logic [7:0] a, input logic [15:0] e);
		rq.push_back(e);
		addr_i <= a;
		rd_i <= 1'b1;
		wr_i <= 1'b0;
		@(posedge sys_clk_i);
	endtask
	task automatic put16(input logic [15:0] v);
		pl.push_back(v[15:8]);
		pl.push_back(v[7:0]);
	endtask
	task automatic frame(input logic [15:0] typ, input logic [7:0] len);
		logic [15:0] c;
		c = crc_step(crc_step(crc_step(16'h0000, typ[15:8]), typ[7:0]), len);
		foreach (pl[i]) c = crc_step(c, pl[i]);
		eq.push_back(8'h55);
		eq.push_back(8'h55);
		eq.push_back(typ[15:8]);
		eq.push_back(typ[7:0]);
		eq.push_back(len);
		foreach (pl[i]) eq.push_back(pl[i]);
		eq.push_back(c[15:8]);
		eq.push_back(c[7:0]);
		pl.delete();
	endtask
	task automatic drain();
		int n;
		n = 0;
		wr_i <= 1'b0;
		rd_i <= 1'b0;
		while (eq.size() != 0 && n < 600) begin
			@(posedge sys_clk_i);
			n++;
		end
		if (eq.size() != 0) begin
			n_fail++;
			$display("FAIL %0t frame incomplete", $time);
			eq.delete();
		end
		repeat (4) @(posedge sys_clk_i);
	endtask
	task automatic req(input logic [15:0] t);
		wr(`ADDR_REQ, t);
		drain();
	endtask
	task automatic tick();
		wr_i <= 1'b0;
		stream_tick_i <= 1'b1;
		@(posedge sys_clk_i);
		stream_tick_i <= 1'b0;
		drain();
	endtask

	// external crc stand-in; the real polynomial lives outside this block
	always @(posedge sys_clk_i) begin
		if (crc_clear_o) crc_i <= 16'h0000;
		else if (crc_take_o) crc_i <= crc_step(crc_i, tx_data_o);
	end
	always @(posedge sys_clk_i) begin
		rd_d <= rd_i;
		if (rd_d) cmp16(rdata_o, rq.pop_front());
		if (got) begin
			if (eq.size() == 0) begin
				n_fail++;
				$display("FAIL %0t unexpected byte", $time);
			end else cmp8(got_data, eq.pop_front());
		end
		cyc++;
		if (cyc == 20000) begin
			n_fail++;
			$display("FAIL %0t timeout", $time);
			end_of_test();
		end
	end

	initial begin
		logic [15:0] v, p;
		repeat (20) @(posedge sys_clk_i);
		rst_i <= 1'b0;
		@(posedge sys_clk_i);
		wr(`ADDR_VER_BUILD, 16'h00A5);
		rd(`ADDR_VER_BUILD, 16'h00A5);
		rd(8'h30, 16'h0000);
		// every stage code, then released firmware
		for (int s = 0; s < 5; s++) begin
			v = rnd();
			p = rnd();
			slow <= s[0];
			wr(`ADDR_CTRL, {14'h0000, s == 4, 1'b0});
			wr(`ADDR_VER_MAJ_MIN, v);
			// released firmware gets a nonzero stored stage so the masking is seen
			wr(`ADDR_VER_PATCH_STAGE, {p[15:8], 6'h00, (s == 4) ? 2'h2 : s[1:0]});
			wr(`ADDR_VER_BUILD, {8'h00, p[7:0]});
			put16(v);
			pl.push_back(p[15:8]);
			pl.push_back(s == 4 ? 8'h00 : {6'h00, s[1:0]});
			pl.push_back(s == 4 ? 8'h00 : p[7:0]);
			frame(16'h5652, 8'h05);
			req(16'h5652);
		end
		wr(`ADDR_SERIAL_HI, 16'h1234);
		wr(`ADDR_SERIAL_LO, 16'hABCD);
		for (int i = 0; i < 6; i++) wr(`ADDR_MODEL_BASE + 8'(i), {8'h00, m[i]});
		wr(`ADDR_MODEL_LEN, 16'h0006);
		put16(16'h1234);
		put16(16'hABCD);
		for (int i = 0; i < 6; i++) pl.push_back(m[i]);
		pl.push_back(8'h00);
		frame(16'h4944, 8'h0B);
		req(16'h4944);
		for (int i = 0; i < 14; i++) begin
			v = rnd();
			test_words_i[16*i +: 16] <= v;
			put16(v);
		end
		frame(16'h5430, 8'h1C);
		req(16'h5430);
		for (int k = 0; k < 2; k++) begin
			for (int i = 0; i < 13; i++) begin
				v = rnd();
				sensor_words_i[16*i +: 16] <= v;
				put16(v);
			end
			put16(16'h0000);
			put16(test_words_i[15:0]);
			frame(16'h5330, 8'h1E);
			if (k == 0) req(16'h5330);
			else begin
				wr(`ADDR_CTRL, 16'h0001);
				tick();
			end
		end
		wr(`ADDR_CTRL, 16'h0000);
		tick();
		put16(16'h1234);
		frame(16'h1515, 8'h02);
		req(16'h1234);
		rd(`ADDR_FAILED_TYPE, 16'h1234);
		rd(`ADDR_REQ, 16'h1515);
		rd(`ADDR_STATUS, 16'h0008);
		wr(`ADDR_STATUS, 16'h0008);
		rd(`ADDR_STATUS, 16'h0000);
		drain();
		end_of_test();
	end
endmodule // polled_info_sensor_packet_framer_bench
`default_nettype wire
